// >>> core/cesr_consts.vh
`ifndef CESR_CONSTS_VH
`define CESR_CONSTS_VH
// Register offsets
`define CESR_ADDR_GAIN_CEIL   8'h1c
`define CESR_ADDR_LUMA_TGT    8'h1d
`define CESR_ADDR_LOOP_CFG    8'h1e
`define CESR_ADDR_EXPL_LO     8'h20
`define CESR_ADDR_EXPL_HI     8'h21
`define CESR_ADDR_EXPC_LO     8'h22
`define CESR_ADDR_EXPC_HI     8'h23
`define CESR_ADDR_WSTART_LO   8'h24
`define CESR_ADDR_WSTART_HI   8'h25
`define CESR_ADDR_WCOUNT_LO   8'h26
`define CESR_ADDR_WCOUNT_HI   8'h27
// Reset values
`define CESR_RST_GAIN_CEIL    8'hff
`define CESR_RST_LUMA_TGT     8'h80
`define CESR_RST_LOOP_CFG     8'h00
`define CESR_RST_EXPL         16'h0000
`define CESR_RST_EXPC         16'h0000
`define CESR_RST_WSTART       16'h0000
`define CESR_RST_WCOUNT       16'h01ee
// Legal maxima
`define CESR_MAX_EXPL         16'h0fff
`define CESR_MAX_EXPC         16'h030b
`define CESR_MAX_WSTART       16'h01ed
`define CESR_MAX_WCOUNT       16'h01ee
// Loop configuration fields
`define CESR_CFG_AE_BIT       0
`define CESR_CFG_AGC_BIT      1
`define CESR_CFG_LONG_BIT     7
`define CESR_CFG_WR_MASK      8'h83
// Scan mode codes
`define CESR_SCAN_FULL        3'h0
`define CESR_SCAN_VAR         3'h7
// Window limits
`define CESR_FULL_LINES       16'h01ee
`define CESR_FIRST_LINE_OFS   16'h0001
// Shutter limit and unmapped read value
`define CESR_MIN_SHUT_CLKS    16'h0132
`define CESR_READ_UNMAPPED    8'h00
`endif

// >>> core/cesr_pair_reg.v
`timescale 1ns/1ps
`default_nettype none
`include "cesr_consts.vh"
module cesr_pair_reg #(
    parameter [15:0] MAX_VAL = 16'hffff,
    parameter [15:0] RST_VAL = 16'h0000
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wr_lo,
    input  wire        wr_hi,
    input  wire [7:0]  wr_data,
    input  wire        apply,
    output reg  [15:0] staged_r,
    output reg  [15:0] active_r
);
    reg  [15:0] raw;
    reg  [15:0] staged_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Byte merge and clamp on write
    always @* begin
        raw = staged_r;
        if (wr_lo) begin
            raw[7:0] = wr_data;
        end
        if (wr_hi) begin
            raw[15:8] = wr_data;
        end
        staged_nxt = (raw > MAX_VAL) ? MAX_VAL : raw;
    end

    ////////////////////////////////////////////////////////////////////////
    // Staged copy, frame-aligned active copy
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            staged_r <= RST_VAL;
            active_r <= RST_VAL;
        end else begin
            staged_r <= staged_nxt;
            if (apply) begin
                active_r <= staged_r;
            end
        end
    end
endmodule // cesr_pair_reg
`default_nettype wire

// >>> core/cesr_shutter.v
`timescale 1ns/1ps
`default_nettype none
`include "cesr_consts.vh"
module cesr_shutter (
    input  wire        clk,
    input  wire        rst,
    input  wire        frame_start,
    input  wire        line_tick,
    input  wire        pix_tick,
    input  wire        long_mode,
    input  wire [15:0] exp_lines,
    input  wire [15:0] exp_clocks,
    output reg         exposing_r,
    output reg         shutter_off_r,
    output wire        frame_hold
);
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_LINES = 2'h1;
    localparam [1:0] ST_CLKS  = 2'h2;
    localparam [1:0] ST_FULL  = 2'h3;

    reg  [1:0]  state_r;
    reg  [15:0] line_cnt_r;
    reg  [15:0] clk_cnt_r;
    wire        busy  = (state_r != ST_IDLE);
    wire        start = frame_start && !frame_hold;
    wire        min_shut = (exp_lines == 16'h0000) && (exp_clocks != 16'h0000)
                           && (exp_clocks <= `CESR_MIN_SHUT_CLKS);

    assign frame_hold = long_mode && busy && (state_r != ST_FULL);

    ////////////////////////////////////////////////////////////////////////
    // Exposure timer: lines first, then pixel clocks
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r       <= ST_IDLE;
            line_cnt_r    <= 16'h0000;
            clk_cnt_r     <= 16'h0000;
            exposing_r    <= 1'b0;
            shutter_off_r <= 1'b0;
        end else begin
            case (state_r)
            ST_LINES: begin
                if (line_tick) begin
                    if (line_cnt_r <= 16'h0001) begin
                        state_r <= (clk_cnt_r == 16'h0000) ? ST_IDLE : ST_CLKS;
                        exposing_r <= (clk_cnt_r != 16'h0000);
                    end
                    line_cnt_r <= line_cnt_r - 16'h0001;
                end
            end
            ST_CLKS: begin
                if (pix_tick) begin
                    if (clk_cnt_r <= 16'h0001) begin
                        state_r    <= ST_IDLE;
                        exposing_r <= 1'b0;
                    end
                    clk_cnt_r <= clk_cnt_r - 16'h0001;
                end
            end
            default: begin
                if (state_r == ST_FULL && frame_start) begin
                    state_r    <= ST_IDLE;
                    exposing_r <= 1'b0;
                end
            end
            endcase
            if (start) begin
                shutter_off_r <= 1'b0;
                exposing_r    <= 1'b1;
                line_cnt_r    <= exp_lines;
                clk_cnt_r     <= min_shut ? `CESR_MIN_SHUT_CLKS : exp_clocks;
                if (exp_lines == 16'h0000 && exp_clocks == 16'h0000) begin
                    state_r       <= ST_FULL;
                    shutter_off_r <= 1'b1;
                end else if (exp_lines == 16'h0000) begin
                    state_r <= ST_CLKS;
                end else begin
                    state_r <= ST_LINES;
                end
            end
        end
    end
endmodule // cesr_shutter
`default_nettype wire

// >>> core/cesr_regs.v
// Overview of operation
// - Gain ceiling is 8 bits, resets 255; applied gain exceeds it only for one clock after it is lowered.
// - Luminance target is 8 bits, resets 128; loop regulates toward it.
// - Loop config bit 1 enables auto gain, bit 0 auto exposure.
// - Loop config resets 0; bit 7 long exposure; host writes zeros to 6..2.
// - Auto plus long exposure: exposure free of frame rate, frame stretches.
// - Exposure is line count times line period plus pixel clocks.
// - Both exposure counts zero: shutter off, full frame exposure.
// - Zero lines and 1 to 306 clocks: minimum shutter exposure.
// - Exposure line count 0..4095, resets 0, larger writes become 4095.
// - Exposure pixel clocks 0..779, resets 0, larger writes become 779.
// - First partial scan line is window start plus one; start resets 0.
// - Window start 0..493, larger writes become 493.
// - Start plus line count above 494 falls back to full scan.
// - Window line count sets image height, resets 494, range 0..494.
// - Window line count writes above 494 become 494.
// - Partial window used only with scan mode code 111; 000 is full.
`timescale 1ns/1ps
`default_nettype none
`include "cesr_consts.vh"
module cesr_regs (
    input  wire        clk,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_r,
    output reg         reg_rvalid_r,
    input  wire [2:0]  scan_mode,
    input  wire        frame_start,
    input  wire        line_tick,
    input  wire        pix_tick,
    input  wire [7:0]  loop_gain_req,
    input  wire [15:0] loop_exp_lines,
    input  wire [15:0] loop_exp_clocks,
    output reg  [7:0]  gain_out_r,
    output reg  [7:0]  luminance_target_r,
    output reg  [7:0]  auto_gain_ceiling_r,
    output wire        auto_gain_en,
    output wire        auto_exposure_en,
    output wire        long_exposure_en,
    output wire        exposing,
    output wire        shutter_off,
    output wire        frame_hold,
    output reg         partial_scan_r,
    output reg  [15:0] first_line_r,
    output reg  [15:0] line_count_r
);
    reg  [7:0]  luminance_loop_config_r;
    wire [15:0] expl_staged;
    wire [15:0] expl_active;
    wire [15:0] expc_staged;
    wire [15:0] expc_active;
    wire [15:0] wstart_staged;
    wire [15:0] wstart_active;
    wire [15:0] wcount_staged;
    wire [15:0] wcount_active;
    wire [15:0] use_lines;
    wire [15:0] use_clocks;
    wire [16:0] window_end;
    wire        window_fits;
    wire        var_mode;
    reg  [7:0]  rdata_nxt;
    reg  [7:0]  gain_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function wr_hit;
        input [7:0] a;
        input [7:0] target;
        begin
            wr_hit = reg_wr && (a == target);
        end
    endfunction

    function [7:0] byte_sel;
        input [15:0] v;
        input        hi;
        begin
            byte_sel = hi ? v[15:8] : v[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Byte registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            auto_gain_ceiling_r     <= `CESR_RST_GAIN_CEIL;
            luminance_target_r      <= `CESR_RST_LUMA_TGT;
            luminance_loop_config_r <= `CESR_RST_LOOP_CFG;
        end else begin
            if (wr_hit(reg_addr, `CESR_ADDR_GAIN_CEIL)) begin
                auto_gain_ceiling_r <= reg_wdata;
            end
            if (wr_hit(reg_addr, `CESR_ADDR_LUMA_TGT)) begin
                luminance_target_r <= reg_wdata;
            end
            if (wr_hit(reg_addr, `CESR_ADDR_LOOP_CFG)) begin
                luminance_loop_config_r <= reg_wdata & `CESR_CFG_WR_MASK;
            end
        end
    end

    assign auto_exposure_en = luminance_loop_config_r[`CESR_CFG_AE_BIT];
    assign auto_gain_en     = luminance_loop_config_r[`CESR_CFG_AGC_BIT];
    assign long_exposure_en = luminance_loop_config_r[`CESR_CFG_LONG_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Sixteen-bit pairs, clamped on write, applied at frame start
    cesr_pair_reg #(
        .MAX_VAL (`CESR_MAX_EXPL),
        .RST_VAL (`CESR_RST_EXPL)
    ) u_expl (
        .clk      (clk),
        .rst      (rst),
        .wr_lo    (wr_hit(reg_addr, `CESR_ADDR_EXPL_LO)),
        .wr_hi    (wr_hit(reg_addr, `CESR_ADDR_EXPL_HI)),
        .wr_data  (reg_wdata),
        .apply    (frame_start),
        .staged_r (expl_staged),
        .active_r (expl_active)
    );

    cesr_pair_reg #(
        .MAX_VAL (`CESR_MAX_EXPC),
        .RST_VAL (`CESR_RST_EXPC)
    ) u_expc (
        .clk      (clk),
        .rst      (rst),
        .wr_lo    (wr_hit(reg_addr, `CESR_ADDR_EXPC_LO)),
        .wr_hi    (wr_hit(reg_addr, `CESR_ADDR_EXPC_HI)),
        .wr_data  (reg_wdata),
        .apply    (frame_start),
        .staged_r (expc_staged),
        .active_r (expc_active)
    );

    cesr_pair_reg #(
        .MAX_VAL (`CESR_MAX_WSTART),
        .RST_VAL (`CESR_RST_WSTART)
    ) u_wstart (
        .clk      (clk),
        .rst      (rst),
        .wr_lo    (wr_hit(reg_addr, `CESR_ADDR_WSTART_LO)),
        .wr_hi    (wr_hit(reg_addr, `CESR_ADDR_WSTART_HI)),
        .wr_data  (reg_wdata),
        .apply    (frame_start),
        .staged_r (wstart_staged),
        .active_r (wstart_active)
    );

    cesr_pair_reg #(
        .MAX_VAL (`CESR_MAX_WCOUNT),
        .RST_VAL (`CESR_RST_WCOUNT)
    ) u_wcount (
        .clk      (clk),
        .rst      (rst),
        .wr_lo    (wr_hit(reg_addr, `CESR_ADDR_WCOUNT_LO)),
        .wr_hi    (wr_hit(reg_addr, `CESR_ADDR_WCOUNT_HI)),
        .wr_data  (reg_wdata),
        .apply    (frame_start),
        .staged_r (wcount_staged),
        .active_r (wcount_active)
    );

    ////////////////////////////////////////////////////////////////////////
    // Exposure source and shutter timer
    assign use_lines  = auto_exposure_en ? loop_exp_lines : expl_active;
    assign use_clocks = auto_exposure_en ? loop_exp_clocks : expc_active;

    cesr_shutter u_shutter (
        .clk           (clk),
        .rst           (rst),
        .frame_start   (frame_start),
        .line_tick     (line_tick),
        .pix_tick      (pix_tick),
        .long_mode     (auto_exposure_en && long_exposure_en),
        .exp_lines     (use_lines),
        .exp_clocks    (use_clocks),
        .exposing_r    (exposing),
        .shutter_off_r (shutter_off),
        .frame_hold    (frame_hold)
    );

    ////////////////////////////////////////////////////////////////////////
    // Gain limit
    always @* begin
        gain_nxt = auto_gain_en ? loop_gain_req : auto_gain_ceiling_r;
        if (gain_nxt > auto_gain_ceiling_r) begin
            gain_nxt = auto_gain_ceiling_r;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gain_out_r <= `CESR_RST_GAIN_CEIL;
        end else begin
            gain_out_r <= gain_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partial scan window
    assign window_end  = {1'b0, wstart_active} + {1'b0, wcount_active};
    assign window_fits = (window_end <= {1'b0, `CESR_FULL_LINES});
    assign var_mode    = (scan_mode == `CESR_SCAN_VAR);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            partial_scan_r <= 1'b0;
            first_line_r   <= `CESR_FIRST_LINE_OFS;
            line_count_r   <= `CESR_FULL_LINES;
        end else begin
            if (var_mode && window_fits) begin
                partial_scan_r <= 1'b1;
                first_line_r   <= wstart_active + `CESR_FIRST_LINE_OFS;
                line_count_r   <= wcount_active;
            end else begin
                partial_scan_r <= 1'b0;
                first_line_r   <= `CESR_FIRST_LINE_OFS;
                line_count_r   <= `CESR_FULL_LINES;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readback
    always @* begin
        case (reg_addr)
        `CESR_ADDR_GAIN_CEIL:  rdata_nxt = auto_gain_ceiling_r;
        `CESR_ADDR_LUMA_TGT:   rdata_nxt = luminance_target_r;
        `CESR_ADDR_LOOP_CFG:   rdata_nxt = luminance_loop_config_r;
        `CESR_ADDR_EXPL_LO:    rdata_nxt = byte_sel(expl_staged, 1'b0);
        `CESR_ADDR_EXPL_HI:    rdata_nxt = byte_sel(expl_staged, 1'b1);
        `CESR_ADDR_EXPC_LO:    rdata_nxt = byte_sel(expc_staged, 1'b0);
        `CESR_ADDR_EXPC_HI:    rdata_nxt = byte_sel(expc_staged, 1'b1);
        `CESR_ADDR_WSTART_LO:  rdata_nxt = byte_sel(wstart_staged, 1'b0);
        `CESR_ADDR_WSTART_HI:  rdata_nxt = byte_sel(wstart_staged, 1'b1);
        `CESR_ADDR_WCOUNT_LO:  rdata_nxt = byte_sel(wcount_staged, 1'b0);
        `CESR_ADDR_WCOUNT_HI:  rdata_nxt = byte_sel(wcount_staged, 1'b1);
        default:               rdata_nxt = `CESR_READ_UNMAPPED;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r  <= `CESR_READ_UNMAPPED;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
        end
    end
endmodule // cesr_regs
`default_nettype wire

// >>> dv/cesr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cesr_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_rd,
    input wire logic [2:0]  scan_mode,
    input wire logic        frame_start,
    input wire logic [7:0]  reg_rdata_r,
    input wire logic        reg_rvalid_r,
    input wire logic [7:0]  gain_out_r,
    input wire logic [7:0]  auto_gain_ceiling_r,
    input wire logic        auto_gain_en,
    input wire logic        auto_exposure_en,
    input wire logic        long_exposure_en,
    input wire logic        exposing,
    input wire logic        shutter_off,
    input wire logic        frame_hold,
    input wire logic        partial_scan_r,
    input wire logic [15:0] first_line_r,
    input wire logic [15:0] line_count_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_read_valid: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read valid missing");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
        else $error("read data changed without read");
    a_gain_cap: assert property ($stable(auto_gain_ceiling_r) |-> gain_out_r <= auto_gain_ceiling_r)
        else $error("gain above ceiling");
    a_gain_off_ceil: assert property (!auto_gain_en && $stable(auto_gain_en)
        && $stable(auto_gain_ceiling_r) |-> gain_out_r == auto_gain_ceiling_r)
        else $error("gain not at ceiling with loop off");
    a_window_full: assert property (!partial_scan_r |->
        first_line_r == 16'h0001 && line_count_r == 16'h01ee)
        else $error("full scan window wrong");
    a_window_sum: assert property (partial_scan_r |-> first_line_r != 16'h0000
        && {1'b0, first_line_r} + {1'b0, line_count_r} <= 17'h001ef)
        else $error("partial window too large");
    a_scan_gate: assert property (scan_mode != 3'h7 && $past(scan_mode) != 3'h7
        |-> !partial_scan_r)
        else $error("partial scan outside variable mode");
    a_shut_start: assert property (frame_start && !frame_hold |=> exposing)
        else $error("exposure did not start");
    a_hold_mode: assert property (frame_hold |-> auto_exposure_en && long_exposure_en)
        else $error("frame hold outside long mode");
    a_off_keeps: assert property (shutter_off && !frame_start |=> shutter_off && exposing)
        else $error("shutter off exposure ended early");
endmodule // cesr_chk
bind cesr_regs cesr_chk u_cesr_chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
    .scan_mode(scan_mode), .frame_start(frame_start), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .gain_out_r(gain_out_r),
    .auto_gain_ceiling_r(auto_gain_ceiling_r), .auto_gain_en(auto_gain_en),
    .auto_exposure_en(auto_exposure_en), .long_exposure_en(long_exposure_en),
    .exposing(exposing), .shutter_off(shutter_off), .frame_hold(frame_hold),
    .partial_scan_r(partial_scan_r), .first_line_r(first_line_r),
    .line_count_r(line_count_r));
`default_nettype wire

// >>> dv/cesr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cesr_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata_r,
    input  wire logic       reg_rvalid_r,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Byte write, bus scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = dat;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~dat;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic vld);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        vld = reg_rvalid_r;
        dat = reg_rdata_r;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // cesr_host
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, rst, reg_wr, reg_rd, frame_start, line_tick, pix_tick, v;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, gain_out_r, loop_gain_req, d;
    logic [7:0]  luminance_target_r, auto_gain_ceiling_r;
    logic        reg_rvalid_r, auto_gain_en, auto_exposure_en, long_exposure_en;
    logic        exposing, shutter_off, frame_hold, partial_scan_r;
    logic [2:0]  scan_mode;
    logic [15:0] loop_exp_lines, loop_exp_clocks, first_line_r, line_count_r;
    logic [7:0]  cyc = 8'h00;
    logic [24:0] rows [0:25];
    int          errors, total_checks, n, i;

    cesr_host u_cesr_host (.clk(clk), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    cesr_regs u_cesr_regs (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .scan_mode(scan_mode), .frame_start(frame_start),
        .line_tick(line_tick), .pix_tick(pix_tick), .loop_gain_req(loop_gain_req),
        .loop_exp_lines(loop_exp_lines), .loop_exp_clocks(loop_exp_clocks),
        .gain_out_r(gain_out_r), .luminance_target_r(luminance_target_r),
        .auto_gain_ceiling_r(auto_gain_ceiling_r), .auto_gain_en(auto_gain_en),
        .auto_exposure_en(auto_exposure_en), .long_exposure_en(long_exposure_en),
        .exposing(exposing), .shutter_off(shutter_off), .frame_hold(frame_hold),
        .partial_scan_r(partial_scan_r), .first_line_r(first_line_r),
        .line_count_r(line_count_r));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // One line period every 16 clocks
    always @(negedge clk) begin
        cyc <= cyc + 8'h01;
        line_tick <= (cyc[3:0] == 4'h0);
    end
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR %0t length %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic frame();
        @(negedge clk);
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
    endtask
    task automatic cnt();
        n = 0;
        while (exposing === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic shut(input logic [15:0] l, input logic [15:0] c);
        u_cesr_host.wr(8'h20, l[7:0]);
        u_cesr_host.wr(8'h21, l[15:8]);
        u_cesr_host.wr(8'h22, c[7:0]);
        u_cesr_host.wr(8'h23, c[15:8]);
        frame();
        while (cyc[3:0] != 4'h0) @(negedge clk);
        frame();
        cnt();
    endtask
    task automatic win(input logic [15:0] s, input logic p, input logic [15:0] f,
                       input logic [15:0] c);
        u_cesr_host.wr(8'h24, s[7:0]);
        u_cesr_host.wr(8'h25, s[15:8]);
        frame();
        @(negedge clk);
        chk({15'h0000, partial_scan_r}, {15'h0000, p});
        chk(first_line_r, f);
        chk(line_count_r, c);
    endtask
    ////////////////////////////////////////
    initial begin
        rows = '{25'h01c00ff, 25'h01d0080, 25'h01e0000, 25'h0200000, 25'h0210000,
                 25'h0220000, 25'h0230000, 25'h0240000, 25'h0250000, 25'h02600ee,
                 25'h0270001, 25'h11c3737, 25'h11d5555, 25'h11eff83, 25'h120ffff,
                 25'h121ff0f, 25'h122ffff, 25'h123ff03, 25'h022000b, 25'h124ffff,
                 25'h1250101, 25'h02400ed, 25'h126ffee, 25'h1270000, 25'h1405a00,
                 25'h02600ee};
        rst = 1'b1;
        frame_start = 1'b0;
        pix_tick = 1'b1;
        scan_mode = 3'h0;
        loop_gain_req = 8'h80;
        loop_exp_lines = 16'h0000;
        loop_exp_clocks = 16'h0000;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 26; i++) begin
            if (rows[i][24])
                u_cesr_host.wr(rows[i][23:16], rows[i][15:8]);
            u_cesr_host.rd(rows[i][23:16], d, v);
            chk({15'h0000, v}, 16'h0001);
            chk({8'h00, d}, {8'h00, rows[i][7:0]});
        end
        frame();
        @(negedge clk);
        chk({8'h00, luminance_target_r}, 16'h0055);
        chk({8'h00, auto_gain_ceiling_r}, 16'h0037);
        chk({13'h0000, long_exposure_en, auto_gain_en, auto_exposure_en}, 16'h0007);
        chk({8'h00, gain_out_r}, 16'h0037);
        loop_gain_req = 8'h10;
        repeat (2) @(negedge clk);
        chk({8'h00, gain_out_r}, 16'h0010);
        u_cesr_host.wr(8'h1e, 8'h00);
        scan_mode = 3'h7;
        win(16'h01ed, 1'b0, 16'h0001, 16'h01ee);
        chk({8'h00, gain_out_r}, 16'h0037);
        win(16'h000a, 1'b1, 16'h000b, 16'h00ee);
        win(16'h0100, 1'b1, 16'h0101, 16'h00ee);
        win(16'h0101, 1'b0, 16'h0001, 16'h01ee);
        scan_mode = 3'h0;
        win(16'h000a, 1'b0, 16'h0001, 16'h01ee);
        shut(16'h0000, 16'h0000);
        chk_rng(n, 2000, 2000);
        chk({15'h0000, shutter_off}, 16'h0001);
        shut(16'h0000, 16'h0001);
        chk_rng(n, 303, 309);
        chk({15'h0000, shutter_off}, 16'h0000);
        shut(16'h0000, 16'h0400);
        chk_rng(n, 776, 782);
        shut(16'h0001, 16'h0000);
        chk_rng(n, 8, 34);
        loop_exp_clocks = 16'h01f4;
        u_cesr_host.wr(8'h1e, 8'h81);
        frame();
        chk({15'h0000, frame_hold}, 16'h0001);
        frame();
        cnt();
        chk_rng(n, 480, 503);
        chk({15'h0000, frame_hold}, 16'h0000);
        final_report();
    end
    initial begin
        #100000;
        errors++;
        final_report();
    end
endmodule // tb
`default_nettype wire
